// ===== hdl/pcs_pkg.sv
package pcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SETUP_NS       = 100;
  localparam int unsigned STROBE_NS      = 250;
  localparam int unsigned HOLD_NS        = 50;
  localparam int unsigned CARD_RESET_NS  = 10000;
  localparam logic [7:0]  SETUP_CYC      = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  STROBE_CYC     = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  HOLD_CYC       = 8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  CARD_RESET_CYC =
    8'((CARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Access kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_MEM_RD = 2'h0;
  localparam logic [1:0] KIND_MEM_WR = 2'h1;
  localparam logic [1:0] KIND_IO_RD  = 2'h2;
  localparam logic [1:0] KIND_IO_WR  = 2'h3;

  // ----------------------------------------------------------------
  // Voltage sense decode (sense lines as a pair)
  // ----------------------------------------------------------------
  localparam logic [1:0] VCLASS_5V    = 2'h0;
  localparam logic [1:0] VCLASS_3V3   = 2'h1;
  localparam logic [1:0] VCLASS_LOWV  = 2'h2;
  localparam logic [1:0] VCLASS_BOTH  = 2'h3;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PCS_IDLE   = 2'b00,
    PCS_SETUP  = 2'b01,
    PCS_STROBE = 2'b11,
    PCS_HOLD   = 2'b10
  } pcs_state_e;

endpackage

// ===== hdl/pcs_sense_decode.sv
`timescale 1ns/10ps
module pcs_sense_decode
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Sense pair
  input  wire logic       voltage_sense_first_in,
  input  wire logic       voltage_sense_second_in,
  // Result
  output logic [1:0]      volt_class_out
);

  logic [1:0] next_volt_class;

  // Both lines decoded together; 0 means grounded
  always_comb
  begin
    case ({voltage_sense_second_in, voltage_sense_first_in})
      2'h3:    next_volt_class = VCLASS_5V;
      2'h2:    next_volt_class = VCLASS_3V3;
      2'h1:    next_volt_class = VCLASS_LOWV;
      default: next_volt_class = VCLASS_BOTH;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      volt_class_out <= VCLASS_5V;
    else
      volt_class_out <= next_volt_class;
  end

  chk_sense_pair: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ({voltage_sense_second_in, voltage_sense_first_in} == 2'h2)
      |=> (volt_class_out == VCLASS_3V3))
    else $error("sense pair decode wrong");

endmodule

// ===== hdl/pcs_socket_ctrl.sv
// Notes on behaviour
// - Attribute select stays high for every common memory access.
// - Attribute select on: memory strobes reach attribute space, I/O strobes I/O space.
// - A reset output forces a hard reset of the card.
// - Operating voltage comes from both sense lines together.
// - Card may stretch a cycle; completion waits while it asks.
// - Write strobe clocks memory write data into the card.
// - With an I/O card outside DMA mode, protect line means wide-port indication.
// - In DMA mode the protect line is taken as a DMA request.
// - Memory reads drive the read-output strobe low.
// - I/O writes drive the I/O write strobe low.
`timescale 1ns/10ps
module pcs_socket_ctrl
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Host request side
  input  wire logic       req_in,
  input  wire logic [1:0] req_kind_in,
  input  wire logic       req_attr_in,
  input  wire logic       io_card_in,
  input  wire logic       dma_mode_in,
  input  wire logic       card_reset_req_in,
  output logic            busy_out,
  output logic            done_out,
  // Card strobes, active low; card reset active high
  output logic            attr_select_n_out,
  output logic            read_output_n_out,
  output logic            write_strobe_n_out,
  output logic            io_read_strobe_n_out,
  output logic            io_write_strobe_n_out,
  output logic            card_reset_out,
  // Card status inputs
  input  wire logic       wait_n_in,
  input  wire logic       write_protect_in,
  input  wire logic       ready_in,
  input  wire logic       voltage_sense_first_in,
  input  wire logic       voltage_sense_second_in,
  // Status toward host
  output logic            write_protected_out,
  output logic            io_port_wide_indication_out,
  output logic            dma_request_out,
  output logic            card_ready_out,
  output logic [1:0]      volt_class_out
);

  // ----------------------------------------------------------------
  // Stretch synchroniser
  // ----------------------------------------------------------------
  logic wait_meta;
  logic wait_sync;
  logic next_wait_meta;
  logic next_wait_sync;
  always_comb
  begin
    next_wait_meta = ~wait_n_in;
    next_wait_sync = wait_meta;
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wait_meta <= 1'b0;
      wait_sync <= 1'b0;
    end
    else
    begin
      wait_meta <= next_wait_meta;
      wait_sync <= next_wait_sync;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  pcs_state_e state;
  pcs_state_e next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [1:0] kind;
  logic [1:0] next_kind;
  logic       attr;
  logic       next_attr;
  logic       next_busy;
  logic       next_done;
  logic       next_attr_n;
  logic       next_rd_n;
  logic       next_we_n;
  logic       next_io_rd_n;
  logic       next_io_wr_n;
  function automatic logic is_io(input logic [1:0] k);
    is_io = k[1];
  endfunction
  always_comb
  begin
    next_state  = state;
    next_count  = count;
    next_kind   = kind;
    next_attr   = attr;
    next_done   = 1'b0;
    case (state)
      PCS_IDLE:
      begin
        if (req_in && !card_reset_out)
        begin
          next_kind  = req_kind_in;
          // I/O space is always reached with attribute select low
          next_attr  = req_attr_in | is_io(req_kind_in);
          next_count = SETUP_CYC;
          next_state = PCS_SETUP;
        end
      end
      PCS_SETUP:
      begin
        if (count <= 8'h01)
        begin
          next_count = STROBE_CYC;
          next_state = PCS_STROBE;
        end
        else
          next_count = count - 8'h01;
      end
      PCS_STROBE:
      begin
        if (count > 8'h01)
          next_count = count - 8'h01;
        else if (!wait_sync)
        begin
          next_count = HOLD_CYC;
          next_state = PCS_HOLD;
        end
      end
      default:
      begin
        if (count <= 8'h01)
        begin
          next_done  = 1'b1;
          next_state = PCS_IDLE;
        end
        else
          next_count = count - 8'h01;
      end
    endcase
    next_busy   = (next_state != PCS_IDLE);
    // Attribute select low only for attribute or I/O cycles
    next_attr_n = !(next_busy && next_attr);
    next_rd_n   = !(next_state == PCS_STROBE && next_kind == KIND_MEM_RD);
    next_we_n   = !(next_state == PCS_STROBE && next_kind == KIND_MEM_WR);
    next_io_rd_n = !(next_state == PCS_STROBE && next_kind == KIND_IO_RD);
    next_io_wr_n = !(next_state == PCS_STROBE && next_kind == KIND_IO_WR);
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state                 <= PCS_IDLE;
      count                 <= 8'h00;
      kind                  <= KIND_MEM_RD;
      attr                  <= 1'b0;
      busy_out              <= 1'b0;
      done_out              <= 1'b0;
      attr_select_n_out     <= 1'b1;
      read_output_n_out     <= 1'b1;
      write_strobe_n_out    <= 1'b1;
      io_read_strobe_n_out  <= 1'b1;
      io_write_strobe_n_out <= 1'b1;
    end
    else
    begin
      state                 <= next_state;
      count                 <= next_count;
      kind                  <= next_kind;
      attr                  <= next_attr;
      busy_out              <= next_busy;
      done_out              <= next_done;
      attr_select_n_out     <= next_attr_n;
      read_output_n_out     <= next_rd_n;
      write_strobe_n_out    <= next_we_n;
      io_read_strobe_n_out  <= next_io_rd_n;
      io_write_strobe_n_out <= next_io_wr_n;
    end
  end

  // ----------------------------------------------------------------
  // Card reset with minimum width
  // ----------------------------------------------------------------
  logic [7:0] rst_count;
  logic [7:0] next_rst_count;
  logic       next_card_reset;
  always_comb
  begin
    next_rst_count = rst_count;
    if (card_reset_req_in)
      next_rst_count = CARD_RESET_CYC;
    else if (rst_count != 8'h00)
      next_rst_count = rst_count - 8'h01;
    next_card_reset = (next_rst_count != 8'h00);
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rst_count      <= 8'h00;
      card_reset_out <= 1'b1;
    end
    else
    begin
      rst_count      <= next_rst_count;
      card_reset_out <= next_card_reset;
    end
  end

  // ----------------------------------------------------------------
  // Protect line meaning by card type and mode
  // ----------------------------------------------------------------
  logic next_wp;
  logic next_wide;
  logic next_dreq;
  always_comb
  begin
    next_wp   = 1'b0;
    next_wide = 1'b0;
    next_dreq = 1'b0;
    if (dma_mode_in)
      next_dreq = write_protect_in;
    else if (io_card_in)
      next_wide = write_protect_in;
    else
      next_wp = write_protect_in;
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      write_protected_out         <= 1'b0;
      io_port_wide_indication_out <= 1'b0;
      dma_request_out             <= 1'b0;
      card_ready_out              <= 1'b0;
    end
    else
    begin
      write_protected_out         <= next_wp;
      io_port_wide_indication_out <= next_wide;
      dma_request_out             <= next_dreq;
      card_ready_out              <= ready_in & ~io_card_in;
    end
  end

  pcs_sense_decode u_sense
  (
    .clk_sys_in              (clk_sys_in),
    .rst_in                  (rst_in),
    .voltage_sense_first_in  (voltage_sense_first_in),
    .voltage_sense_second_in (voltage_sense_second_in),
    .volt_class_out          (volt_class_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_strobe_on;
    !read_output_n_out || !write_strobe_n_out
      || !io_read_strobe_n_out || !io_write_strobe_n_out;
  endsequence
  chk_common_attr_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (next_state == PCS_SETUP && !next_attr) |=> attr_select_n_out [*8])
    else $error("attribute select low on common access");
  chk_io_attr_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!io_read_strobe_n_out || !io_write_strobe_n_out) |-> !attr_select_n_out)
    else $error("io strobe without attribute select");
  chk_reset_width: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    card_reset_req_in |=> card_reset_out [*8])
    else $error("card reset too short");
  chk_wait_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == PCS_STROBE && wait_sync) |=> (state == PCS_STROBE) and s_strobe_on)
    else $error("strobe dropped during wait");
  chk_write_strobe: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !write_strobe_n_out |-> (kind == KIND_MEM_WR && state == PCS_STROBE))
    else $error("write strobe out of place");
  chk_wide_map: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (io_card_in && !dma_mode_in && write_protect_in) |=> io_port_wide_indication_out)
    else $error("wide port not reported");
  chk_dma_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (dma_mode_in && write_protect_in) |=> dma_request_out && !write_protected_out)
    else $error("dma request not reported");
  chk_read_strobe: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == PCS_SETUP && count == 8'h01 && kind == KIND_MEM_RD) |=> !read_output_n_out)
    else $error("read strobe missing");
  chk_io_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !io_write_strobe_n_out |-> kind == KIND_IO_WR)
    else $error("io write strobe wrong kind");

endmodule

// ===== verification/pcs_card_model.sv
`timescale 1ns/10ps
module pcs_card_model
  import pcs_pkg::*;
(
  // Clock
  input  wire logic       clk_sys_in,
  // Controller strobes
  input  wire logic       any_strobe_n_in,
  input  wire logic       write_strobe_n_in,
  // Scenario control
  input  wire logic [3:0] stretch_in,
  input  wire logic       protect_in,
  // Card lines
  output logic            wait_n_out,
  output logic            write_protect_out,
  output logic            ready_out
);
  logic [3:0] wait_cnt = 4'h0;
  logic [1:0] busy_cnt = 2'h0;
  logic       wr_q     = 1'b1;

  always @(posedge clk_sys_in)
  begin
    wr_q <= write_strobe_n_in;
    if (any_strobe_n_in)
      wait_cnt <= stretch_in;
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
    if (write_strobe_n_in && !wr_q)
      busy_cnt <= 2'h3;
    else if (busy_cnt != 2'h0)
      busy_cnt <= busy_cnt - 2'h1;
  end

  // Stretch counted from strobe start
  assign wait_n_out        = any_strobe_n_in || (wait_cnt == 4'h0);
  assign write_protect_out = protect_in;
  assign ready_out         = (busy_cnt == 2'h0);
endmodule

// ===== verification/test_pcs_socket_ctrl.sv
`timescale 1ns/10ps
module test_pcs_socket_ctrl;
  import pcs_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, req_in = 0, req_attr_in = 0, io_card_in = 0;
  logic dma_mode_in = 0, card_reset_req_in = 0, sense_first = 0, sense_second = 0, wp = 0;
  logic [1:0] req_kind_in = 2'h0;
  logic [3:0] stretch = 4'h0;
  logic busy_out, done_out, attr_n, rd_n, wr_n, io_rd_n, io_wr_n, card_reset_out;
  logic wait_n, wp_line, ready, prot, wide, dma_req, card_ready;
  logic [1:0] volt_class_out;
  logic [3:0] stb_n;
  int mismatches = 0, checks = 0;

  always #25 clk_sys_in = ~clk_sys_in;
  assign stb_n = {io_wr_n, io_rd_n, wr_n, rd_n};

  pcs_socket_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req_in),
    .req_kind_in(req_kind_in), .req_attr_in(req_attr_in), .io_card_in(io_card_in),
    .dma_mode_in(dma_mode_in), .card_reset_req_in(card_reset_req_in), .busy_out(busy_out),
    .done_out(done_out), .attr_select_n_out(attr_n), .read_output_n_out(rd_n),
    .write_strobe_n_out(wr_n), .io_read_strobe_n_out(io_rd_n),
    .io_write_strobe_n_out(io_wr_n), .card_reset_out(card_reset_out), .wait_n_in(wait_n),
    .write_protect_in(wp_line), .ready_in(ready), .voltage_sense_first_in(sense_first),
    .voltage_sense_second_in(sense_second), .write_protected_out(prot),
    .io_port_wide_indication_out(wide), .dma_request_out(dma_req),
    .card_ready_out(card_ready), .volt_class_out(volt_class_out));

  pcs_card_model card (.clk_sys_in(clk_sys_in), .any_strobe_n_in(&stb_n),
    .write_strobe_n_in(wr_n), .stretch_in(stretch), .protect_in(wp),
    .wait_n_out(wait_n), .write_protect_out(wp_line), .ready_out(ready));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected {dma request, wide port, protected}
  function automatic logic [2:0] exp_status(input logic io, input logic dma, input logic w);
    if (dma)
      return {w, 2'h0};
    return io ? {1'b0, w, 1'b0} : {2'h0, w};
  endfunction

  task run_cycle(input logic [1:0] k, input logic a, input logic [3:0] s);
    int n;
    int t;
    n = 0;
    t = 0;
    stretch = s;
    req_kind_in = k;
    req_attr_in = a;
    req_in = 1;
    repeat (2) @(negedge clk_sys_in);
    req_in = 0;
    while (done_out !== 1'b1 && t < 200)
    begin
      if (stb_n[k] === 1'b0)
      begin
        n++;
        check(attr_n, (a || k[1]) ? 0 : 1);
      end
      check(stb_n | (4'h1 << k), 4'hF);
      @(negedge clk_sys_in);
      t++;
    end
    check(done_out, 1);
    if (s == 0)
      check(n, STROBE_CYC);
    else
      check(n >= s && n <= s + 4, 1);
    check(attr_n, 1);
  endtask

  initial
  begin
    #(50 * 20000);
    mismatches++;
    finish_test;
  end

  initial
  begin
    logic [2:0] r;
    int n;
    r = 3'($urandom(32'h3AD8));
    repeat (12) @(negedge clk_sys_in);
    check(stb_n, 4'hF);
    check({attr_n, busy_out, card_reset_out}, 3'h5);
    rst_in = 0;
    repeat (2) @(negedge clk_sys_in);
    check(card_reset_out, 0);
    card_reset_req_in = 1;
    @(negedge clk_sys_in);
    check(card_reset_out, 1);
    req_in = 1;
    @(negedge clk_sys_in);
    req_in = 0;
    card_reset_req_in = 0;
    @(negedge clk_sys_in);
    check(busy_out, 0);
    n = 1;
    while (card_reset_out === 1'b1 && n < 300)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check(n >= 199 && n <= 202, 1);
    $display("card reset test done");

    for (int k = 0; k < 4; k++)
    begin
      run_cycle(2'(k), 1'b0, 4'h0);
      run_cycle(2'(k), 1'b1, 4'hC);
    end
    for (int i = 0; i < 24; i++)
      run_cycle(2'($urandom), 1'($urandom), ($urandom % 2) ? 4'(8 + $urandom % 8) : 4'h0);
    $display("cycle test done");

    for (int i = 0; i < 24; i++)
    begin
      r = 3'($urandom);
      {io_card_in, dma_mode_in, wp} = r;
      repeat (2) @(negedge clk_sys_in);
      check({dma_req, wide, prot}, exp_status(r[2], r[1], r[0]));
      check(card_ready, !r[2]);
    end
    $display("status test done");

    for (int v = 0; v < 4; v++)
    begin
      {sense_second, sense_first} = 2'(v);
      repeat (2) @(negedge clk_sys_in);
      check(volt_class_out, 2'h3 - 2'(v));
    end
    $display("sense test done");
    finish_test;
  end
endmodule
